/* File: rtl/eepw_pkg.sv */
// constants, types and command tables shared by the page-write host controller
package eepw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and bus widths
  localparam int CLK_NS = 10;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 8;
  localparam int TIMER_W = 20;
  localparam int LEN_W = 7;
  localparam int SEQ_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // timing figures in their own units
  localparam int T_WP_NS = 100;
  localparam int T_WPH_NS = 50;
  localparam int T_ACC_NS = 120;
  localparam int T_OEHP_NS = 150;
  localparam int BLC_US = 150;
  localparam int WC_MS = 10;

  // least times round up to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_WP_CYC = ceil_cyc(T_WP_NS);
  localparam int T_WPH_CYC = ceil_cyc(T_WPH_NS);
  localparam int T_ACC_CYC = ceil_cyc(T_ACC_NS);
  localparam int T_OEHP_CYC = ceil_cyc(T_OEHP_NS);
  // longest times round down
  localparam int BLC_CYC = (BLC_US * 1000) / CLK_NS;
  localparam int WC_CYC = (WC_MS * 1000000) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // operations and lock command sequences
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOCK_WRITE = 2'h2,
    OP_UNLOCK_WRITE = 2'h3
  } eepw_op_e;

  localparam logic [SEQ_W-1:0] LOCK_SEQ_LEN = 3'h3;
  localparam logic [SEQ_W-1:0] UNLOCK_SEQ_LEN = 3'h6;
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 15'h5555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 15'h2aaa;
  localparam logic [DATA_W-1:0] CMD_KEY_A = 8'haa;
  localparam logic [DATA_W-1:0] CMD_KEY_B = 8'h55;
  localparam logic [DATA_W-1:0] CMD_LOCK = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_1 = 8'h80;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_2 = 8'h20;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [SEQ_W-1:0] idx);
    return (idx == 3'h1 || idx == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
  endfunction

  function automatic logic [DATA_W-1:0] seq_data(input logic unlock, input logic [SEQ_W-1:0] idx);
    logic [DATA_W-1:0] d;
    unique case (idx)
      3'h0, 3'h3: d = CMD_KEY_A;
      3'h1, 3'h4: d = CMD_KEY_B;
      3'h2: d = unlock ? CMD_UNLOCK_1 : CMD_LOCK;
      default: d = CMD_UNLOCK_2;
    endcase
    return d;
  endfunction

endpackage

/* File: rtl/eepw_fifo.sv */
// small flip-flop fifo carrying payload bytes toward the page loader
`timescale 1ns/1ns
module eepw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic push, pop;

  assign push = in_valid_in && ready_reg;
  assign pop = out_ready_in && (count_reg != '0);
  assign in_ready_out = ready_reg;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_in;
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    ready_next = (count_next != FULL_CNT);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
    mem_reg <= mem_next;
  end

endmodule

/* File: rtl/eepw_poll.sv */
// end-of-write detector: data polling or toggle comparison of successive reads
`timescale 1ns/1ns
module eepw_poll (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic sample_in,
  input wire logic toggle_mode_in,
  input wire logic expect_in,
  input wire logic [eepw_pkg::DATA_W-1:0] data_in,
  output logic done_out
);
  logic have_prev_reg, have_prev_next;
  logic prev_reg, prev_next;

  // toggle mode trusts no absolute level, only two equal reads in a row
  assign done_out = sample_in && (toggle_mode_in ?
                    (have_prev_reg && (prev_reg == data_in[eepw_pkg::TOGGLE_BIT])) :
                    (data_in[eepw_pkg::POLL_BIT] == expect_in));

  always_comb begin
    have_prev_next = have_prev_reg;
    prev_next = prev_reg;
    if (start_in) begin
      have_prev_next = 1'b0;
    end else if (sample_in) begin
      have_prev_next = 1'b1;
      prev_next = data_in[eepw_pkg::TOGGLE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      have_prev_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      have_prev_reg <= have_prev_next;
      prev_reg <= prev_next;
    end
  end

endmodule

/* File: rtl/eepw_host.sv */
// host controller for a parallel page-write eeprom with software write lock
// Function
// - page lines held during page load
// - next byte within byte load window
// - zero to 64 payload bytes per cycle, at least one for a plain write
// - same page after unlock code entered
// - command bytes and addresses in hex
// - toggle reads keep one fixed address
// - compare successive toggle reads, not levels
// - command sequences follow page write timing
`timescale 1ns/1ns
module eepw_host #(
  parameter int BLC_CYC = eepw_pkg::BLC_CYC,
  parameter int WC_CYC = eepw_pkg::WC_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [1:0] cmd_op_in,
  input wire logic [eepw_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [eepw_pkg::LEN_W-1:0] cmd_len_in,
  input wire logic cmd_toggle_in,
  input wire logic [eepw_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [eepw_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic err_out,
  output logic locked_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic [eepw_pkg::ADDR_W-1:0] addr_out,
  output logic [eepw_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [eepw_pkg::DATA_W-1:0] dq_in
);
  localparam int AW = eepw_pkg::ADDR_W;
  localparam int DW = eepw_pkg::DATA_W;
  localparam int TW = eepw_pkg::TIMER_W;
  localparam int CW = eepw_pkg::CNT_W;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_SEQ = 9'h002,
    ST_LOAD = 9'h004,
    ST_WLO = 9'h008,
    ST_WHI = 9'h010,
    ST_PGAP = 9'h020,
    ST_PRD = 9'h040,
    ST_READ = 9'h080,
    ST_END = 9'h100
  } eepw_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // state
  eepw_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [TW-1:0] gap_reg, gap_next, wc_reg, wc_next;
  logic [eepw_pkg::LEN_W-1:0] len_reg, len_next, idx_reg, idx_next;
  logic [eepw_pkg::SEQ_W-1:0] seq_reg, seq_next, seq_len_reg, seq_len_next;
  logic in_seq_reg, in_seq_next, unlock_reg, unlock_next, toggle_reg, toggle_next;
  logic [AW-1:0] base_reg, base_next;
  logic [DW-1:0] last_data_reg, last_data_next;
  logic lock_set_reg, lock_set_next, lock_clr_reg, lock_clr_next;
  logic locked_reg, locked_next, err_flag_reg, err_flag_next;
  logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [DW-1:0] dq_reg, dq_next, rd_data_reg, rd_data_next;
  logic dq_oe_reg, dq_oe_next, rd_valid_reg, rd_valid_next;
  logic done_reg, done_next, err_reg, err_next, ready_reg, ready_next;

  logic [DW-1:0] fifo_data;
  logic fifo_valid, fifo_pop, poll_start, poll_sample, poll_done;

  ////////////////////////////////////////////////////////////////////////////
  // payload buffer and end-of-write detector
  eepw_fifo #(.WIDTH(DW), .DEPTH(eepw_pkg::FIFO_DEPTH)) eepw_fifo_inst (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_data_in(wr_data_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  assign poll_sample = (state_reg == ST_PRD) && (cnt_reg == '0);

  eepw_poll eepw_poll_inst (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(poll_start),
    .sample_in(poll_sample),
    .toggle_mode_in(toggle_reg),
    .expect_in(last_data_reg[eepw_pkg::POLL_BIT]),
    .data_in(dq_in),
    .done_out(poll_done)
  );

  assign fifo_pop = (state_reg == ST_LOAD) && fifo_valid;
  // a lapsed load starts polling too, so no stale read is compared
  assign poll_start = (state_next == ST_PGAP) && ((state_reg == ST_WHI) || (state_reg == ST_LOAD));

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    gap_next = (gap_reg != '1) ? gap_reg + 1'b1 : gap_reg;
    wc_next = wc_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    seq_next = seq_reg;
    seq_len_next = seq_len_reg;
    in_seq_next = in_seq_reg;
    unlock_next = unlock_reg;
    toggle_next = toggle_reg;
    base_next = base_reg;
    last_data_next = last_data_reg;
    lock_set_next = lock_set_reg;
    lock_clr_next = lock_clr_reg;
    locked_next = locked_reg;
    err_flag_next = err_flag_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    done_next = 1'b0;
    err_next = 1'b0;
    ready_next = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        ready_next = 1'b1;
        if (cmd_valid_in && ready_reg) begin
          ready_next = 1'b0;
          base_next = cmd_addr_in;
          len_next = cmd_len_in;
          gap_next = '0;
          idx_next = '0;
          seq_next = '0;
          err_flag_next = 1'b0;
          unlock_next = (cmd_op_in == eepw_pkg::OP_UNLOCK_WRITE);
          lock_set_next = (cmd_op_in == eepw_pkg::OP_LOCK_WRITE);
          lock_clr_next = (cmd_op_in == eepw_pkg::OP_UNLOCK_WRITE);
          in_seq_next = cmd_op_in[1];
          seq_len_next = (cmd_op_in == eepw_pkg::OP_UNLOCK_WRITE) ?
                         eepw_pkg::UNLOCK_SEQ_LEN : eepw_pkg::LOCK_SEQ_LEN;
          // with no payload there is no byte to poll, so toggle mode is forced
          toggle_next = cmd_toggle_in || (cmd_len_in == '0);
          ce_n_next = 1'b0;
          if (cmd_op_in == eepw_pkg::OP_READ) begin
            addr_next = cmd_addr_in;
            oe_n_next = 1'b0;
            cnt_next = CW'(eepw_pkg::T_ACC_CYC - 1);
            state_next = ST_READ;
          end else if (cmd_len_in > eepw_pkg::LEN_W'(eepw_pkg::PAGE_BYTES) || (cmd_len_in == '0 && !cmd_op_in[1])) begin
            ce_n_next = 1'b1;
            err_next = 1'b1;
            done_next = 1'b1;
            state_next = ST_END;
          end else if (cmd_op_in[1]) begin
            state_next = ST_SEQ;
          end else begin
            state_next = ST_LOAD;
          end
        end
      end
      ST_SEQ: begin
        addr_next = eepw_pkg::seq_addr(seq_reg);
        dq_next = eepw_pkg::seq_data(unlock_reg, seq_reg);
        dq_oe_next = 1'b1;
        we_n_next = 1'b0;
        gap_next = '0;
        cnt_next = CW'(eepw_pkg::T_WP_CYC - 1);
        state_next = ST_WLO;
      end
      ST_LOAD: begin
        if (fifo_valid) begin
          // page lines fixed, only the byte offset moves
          addr_next = {base_reg[AW-1:eepw_pkg::PAGE_LSB],
                       base_reg[eepw_pkg::PAGE_LSB-1:0] + idx_reg[eepw_pkg::PAGE_LSB-1:0]};
          dq_next = fifo_data;
          last_data_next = fifo_data;
          dq_oe_next = 1'b1;
          we_n_next = 1'b0;
          gap_next = '0;
          idx_next = idx_reg + 1'b1;
          cnt_next = CW'(eepw_pkg::T_WP_CYC - 1);
          state_next = ST_WLO;
        end else if (gap_reg >= TW'(BLC_CYC - 1)) begin
          err_flag_next = 1'b1;
          toggle_next = toggle_reg || (idx_reg == '0) || in_seq_reg;
          cnt_next = CW'(eepw_pkg::T_OEHP_CYC - 1);
          wc_next = '0;
          state_next = ST_PGAP;
        end
      end
      ST_WLO: begin
        if (cnt_reg == '0) begin
          we_n_next = 1'b1;
          cnt_next = CW'(eepw_pkg::T_WPH_CYC - 1);
          state_next = ST_WHI;
        end
      end
      ST_WHI: begin
        if (cnt_reg == '0) begin
          dq_oe_next = 1'b0;
          if (in_seq_reg && (seq_reg != seq_len_reg - 1'b1)) begin
            seq_next = seq_reg + 1'b1;
            state_next = ST_SEQ;
          end else if (idx_reg != len_reg) begin
            in_seq_next = 1'b0;
            state_next = ST_LOAD;
          end else begin
            in_seq_next = 1'b0;
            // poll the last byte address and hold it
            if (idx_reg != '0) begin
              addr_next = {base_reg[AW-1:eepw_pkg::PAGE_LSB],
                           base_reg[eepw_pkg::PAGE_LSB-1:0] + idx_reg[eepw_pkg::PAGE_LSB-1:0] - 1'b1};
            end
            cnt_next = CW'(eepw_pkg::T_OEHP_CYC - 1);
            wc_next = '0;
            state_next = ST_PGAP;
          end
        end
      end
      ST_PGAP: begin
        wc_next = wc_reg + 1'b1;
        if (cnt_reg == '0) begin
          oe_n_next = 1'b0;
          cnt_next = CW'(eepw_pkg::T_ACC_CYC - 1);
          state_next = ST_PRD;
        end
      end
      ST_PRD: begin
        wc_next = wc_reg + 1'b1;
        if (cnt_reg == '0) begin
          oe_n_next = 1'b1;
          // end of write seen by the detector
          if (poll_done) begin
            rd_data_next = dq_in;
            // lock state follows a finished write period
            if (lock_set_reg) begin
              locked_next = 1'b1;
            end
            if (lock_clr_reg) begin
              locked_next = 1'b0;
            end
            ce_n_next = 1'b1;
            done_next = 1'b1;
            err_next = err_flag_reg;
            state_next = ST_END;
          // give up after the longest write cycle
          end else if (wc_reg >= TW'(WC_CYC)) begin
            ce_n_next = 1'b1;
            done_next = 1'b1;
            err_next = 1'b1;
            state_next = ST_END;
          end else begin
            cnt_next = CW'(eepw_pkg::T_OEHP_CYC - 1);
            state_next = ST_PGAP;
          end
        end
      end
      ST_READ: begin
        if (cnt_reg == '0) begin
          rd_data_next = dq_in;
          rd_valid_next = 1'b1;
          done_next = 1'b1;
          oe_n_next = 1'b1;
          ce_n_next = 1'b1;
          state_next = ST_END;
        end
      end
      ST_END: begin
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        dq_oe_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      gap_reg <= '0;
      wc_reg <= '0;
      len_reg <= '0;
      idx_reg <= '0;
      seq_reg <= '0;
      seq_len_reg <= '0;
      in_seq_reg <= 1'b0;
      unlock_reg <= 1'b0;
      toggle_reg <= 1'b0;
      base_reg <= '0;
      last_data_reg <= '0;
      lock_set_reg <= 1'b0;
      lock_clr_reg <= 1'b0;
      locked_reg <= 1'b0;
      err_flag_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      addr_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      gap_reg <= gap_next;
      wc_reg <= wc_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      seq_reg <= seq_next;
      seq_len_reg <= seq_len_next;
      in_seq_reg <= in_seq_next;
      unlock_reg <= unlock_next;
      toggle_reg <= toggle_next;
      base_reg <= base_next;
      last_data_reg <= last_data_next;
      lock_set_reg <= lock_set_next;
      lock_clr_reg <= lock_clr_next;
      locked_reg <= locked_next;
      err_flag_reg <= err_flag_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      done_reg <= done_next;
      err_reg <= err_next;
      ready_reg <= ready_next;
    end
  end

  assign cmd_ready_out = ready_reg;
  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign done_out = done_reg;
  assign err_out = err_reg;
  assign locked_out = locked_reg;
  assign ce_n_out = ce_n_reg;
  assign oe_n_out = oe_n_reg;
  assign we_n_out = we_n_reg;
  assign addr_out = addr_reg;
  assign dq_out = dq_reg;
  assign dq_oe_out = dq_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic pay_phase, poll_phase;
  logic [1:0] samples_reg;
  assign pay_phase = !in_seq_reg && (state_reg == ST_WLO) && (idx_reg != '0);
  assign poll_phase = (state_reg == ST_PGAP) || (state_reg == ST_PRD);
  always_ff @(posedge clk_in) begin
    if (srst_in || poll_start) begin
      samples_reg <= '0;
    end else if (poll_sample && samples_reg != 2'h3) begin
      samples_reg <= samples_reg + 1'b1;
    end
  end

  a_page_lines_held: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(we_n_out) && pay_phase |-> addr_out[AW-1:6] == base_reg[AW-1:6])
    else $error("page lines moved during load");
  a_byte_window: assert property (@(posedge clk_in) disable iff (srst_in)
    (state_reg == ST_LOAD) |-> gap_reg < TW'(BLC_CYC))
    else $error("byte load window exceeded");
  a_payload_bound: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(we_n_out) && pay_phase |-> idx_reg <= len_reg && idx_reg <= 7'h40)
    else $error("too many payload bytes");
  a_same_page_unlock: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(we_n_out) && pay_phase && (lock_set_reg || lock_clr_reg) |-> addr_out[AW-1:6] == base_reg[AW-1:6])
    else $error("page changed after code");
  a_seq_bytes: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(we_n_out) && in_seq_reg |-> dq_out == eepw_pkg::seq_data(unlock_reg, seq_reg) && dq_oe_out)
    else $error("wrong command byte");
  a_poll_addr_fixed: assert property (@(posedge clk_in) disable iff (srst_in)
    poll_phase && $past(poll_phase) |-> $stable(addr_out))
    else $error("poll address moved");
  a_toggle_two_reads: assert property (@(posedge clk_in) disable iff (srst_in)
    poll_sample && poll_done && toggle_reg |-> samples_reg != 2'h0)
    else $error("toggle done on a single read");
  a_we_pulse_width: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(we_n_out) |-> ##9 !we_n_out ##1 we_n_out)
    else $error("write pulse width wrong");
  a_oe_high_write: assert property (@(posedge clk_in) disable iff (srst_in)
    !we_n_out |-> oe_n_out && !ce_n_out && dq_oe_out)
    else $error("oe low during write");
  a_lock_after_poll: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(locked_out) |-> done_out && !err_out)
    else $error("lock set without finished write");

  c_lock_write: cover property (@(posedge clk_in) $rose(locked_out));
  c_unlock_write: cover property (@(posedge clk_in) $fell(locked_out));
  c_toggle_done: cover property (@(posedge clk_in) poll_sample && poll_done && toggle_reg);
  c_data_poll_done: cover property (@(posedge clk_in) poll_sample && poll_done && !toggle_reg);
  c_read: cover property (@(posedge clk_in) rd_valid_out);

endmodule

/* File: verif/eepw_dev_model.sv */
// behavioural page-write eeprom with software write lock, sampled on the host clock
`timescale 1ns/1ns
module eepw_dev_model #(
  parameter int WC = 300
) (
  input wire logic clk_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic busy_out
);
  logic [7:0] mem [logic [14:0]];
  logic [137:0] hs = '0;
  logic [22:0] v = '0;
  logic [7:0] ld = 8'h00;
  logic pwe = 1, poe = 1, tog = 0, lk = 0, lk_nx = 0, ok = 0;
  int cnt = 0;
  initial dq_out = 8'h5a;
  assign busy_out = (cnt != 0);
  always @(posedge clk_in) begin
    if (!we_n_in && !ce_n_in) v = {addr_in, dq_in};
    if (we_n_in && !pwe) begin
      // timer restarts on every byte, even when nothing is stored
      cnt = WC;
      hs = {hs[114:0], v};
      ld = v[7:0];
      if (hs[68:0] == {15'h5555, 8'haa, 15'h2aaa, 8'h55, 15'h5555, 8'ha0}) begin
        lk_nx = 1;
        ok = 1;
      end else if (hs == {15'h5555, 8'haa, 15'h2aaa, 8'h55, 15'h5555, 8'h80, 15'h5555, 8'haa, 15'h2aaa, 8'h55,
                          15'h5555, 8'h20}) begin
        lk_nx = 0;
        ok = 1;
      end else if (!lk || ok) mem[v[22:8]] = v[7:0];
    end else if (cnt > 0 && we_n_in) begin
      cnt = cnt - 1;
      // lock state changes only as the write period ends
      if (cnt == 0) begin
        lk = lk_nx;
        ok = 0;
      end
    end
    // bit six flips on each new read while busy
    if (!oe_n_in && poe && busy_out) tog = !tog;
    // poll bit reads inverted while busy
    if (!ce_n_in && !oe_n_in) dq_out <= busy_out ? {~ld[7], tog, ld[5:0]} : (mem.exists(addr_in) ? mem[addr_in] : 8'hff);
    else dq_out <= ~dq_out;
    pwe = we_n_in;
    poe = oe_n_in;
  end
endmodule

/* File: verif/eepw_host_test.sv */
// self-checking bench for the page-write host controller against a device model
`timescale 1ns/1ns
module eepw_host_test;
  localparam logic [137:0] UNL = {15'h5555, 8'haa, 15'h2aaa, 8'h55, 15'h5555, 8'h80, 15'h5555, 8'haa, 15'h2aaa,
                                  8'h55, 15'h5555, 8'h20};
  logic clk_in = 0, srst_in = 1, cmd_valid_in = 0, cmd_toggle_in = 0, wr_valid_in = 0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [14:0] cmd_addr_in = 15'h0000, addr_out;
  logic [6:0] cmd_len_in = 7'h00;
  logic [7:0] wr_data_in = 8'h00, rd_data_out, dq_out, dq_in, dev_q, rd_seen;
  logic cmd_ready_out, wr_ready_out, rd_valid_out, done_out, err_out, locked_out;
  logic ce_n_out, oe_n_out, we_n_out, dq_oe_out, busy, pwe = 1, err_seen;
  logic [22:0] wq [$];
  int miscompares = 0, checks = 0;
  assign dq_in = dq_oe_out ? dq_out : dev_q;
  eepw_host #(.BLC_CYC(200), .WC_CYC(2000)) eepw_host_inst (.clk_in, .srst_in, .cmd_valid_in, .cmd_ready_out,
    .cmd_op_in, .cmd_addr_in, .cmd_len_in, .cmd_toggle_in, .wr_data_in, .wr_valid_in, .wr_ready_out, .rd_data_out,
    .rd_valid_out, .done_out, .err_out, .locked_out, .ce_n_out, .oe_n_out, .we_n_out, .addr_out, .dq_out,
    .dq_oe_out, .dq_in);
  eepw_dev_model eepw_dev_model_inst (.clk_in, .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
    .addr_in(addr_out), .dq_in(dq_in), .dq_out(dev_q), .busy_out(busy));
  initial forever #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [71:0] seen, input logic [71:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task push(input logic [7:0] d);
    @(negedge clk_in);
    wr_valid_in = 1;
    wr_data_in = d;
    while (wr_ready_out !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    wr_valid_in = 0;
  endtask
  task cmd(input logic [1:0] op, input logic [14:0] a, input logic [6:0] n, input logic tg);
    int i;
    @(negedge clk_in);
    cmd_valid_in = 1;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_len_in = n;
    cmd_toggle_in = tg;
    while (cmd_ready_out !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 0;
    for (i = 0; i < 5000 && done_out !== 1'b1; i++) @(negedge clk_in);
    chk(i < 5000, 1);
    chk(rd_valid_out, op == 2'h0);
    err_seen = err_out;
    rd_seen = rd_data_out;
  endtask
  // address and data logged at each falling write strobe
  always @(negedge clk_in) begin
    if (!we_n_out && pwe) wq.push_back({addr_out, dq_out});
    pwe = we_n_out;
    // polling reads stay on the last written address
    if (!oe_n_out && !ce_n_out && busy && wq.size() > 0) chk(addr_out, wq[$][22:8]);
  end
  ////////////////////////////////////////////////////////////////////////////
  task t_page;
    int i;
    wq.delete();
    for (i = 0; i < 4; i++) push(8'(8'h30 + i));
    @(negedge clk_in);
    chk(wr_ready_out, 0);
    fork
      cmd(2'h1, 15'h00fe, 7'h05, 0);
      push(8'h34);
    join
    chk(err_seen, 0);
    // one page, offset wraps inside it
    for (i = 0; i < 5; i++) chk(wq[i], {15'h00c0 | 15'((i + 62) % 64), 8'(8'h30 + i)});
    cmd(2'h0, 15'h00c1, 7'h00, 0);
    chk(rd_seen, 8'h33);
    wq.delete();
    fork
      cmd(2'h1, 15'h0400, 7'h40, 1);
      for (i = 0; i < 64; i++) push(8'(i));
    join
    // full page with toggle end detection
    chk({wq.size(), err_seen}, {32'h0000_0040, 1'b0});
    chk(wq[63][22:8], 15'h043f);
    $display("t_page finished");
  endtask
  task t_lock;
    int i;
    wq.delete();
    cmd(2'h2, 15'h0000, 7'h00, 1);
    chk({locked_out, wq[0], wq[1], wq[2]}, {1'b1, UNL[137:92], 15'h5555, 8'ha0});
    push(8'hc3);
    cmd(2'h1, 15'h0200, 7'h01, 1);
    chk(err_seen, 0);
    cmd(2'h0, 15'h0200, 7'h00, 0);
    // unprotected write leaves the byte erased
    chk({err_seen, rd_seen, locked_out}, {1'b0, 8'hff, 1'b1});
    wq.delete();
    push(8'h5a);
    push(8'ha5);
    cmd(2'h2, 15'h0240, 7'h02, 0);
    // payload after the code on one page
    chk({wq[3], wq[4]}, {15'h0240, 8'h5a, 15'h0241, 8'ha5});
    cmd(2'h0, 15'h0241, 7'h00, 0);
    chk(rd_seen, 8'ha5);
    wq.delete();
    cmd(2'h3, 15'h0000, 7'h00, 1);
    chk(locked_out, 0);
    for (i = 0; i < 6; i++) chk(wq[i], UNL[137 - 23 * i -: 23]);
    $display("t_lock finished");
  endtask
  task t_bad;
    wq.delete();
    cmd(2'h1, 15'h0300, 7'h00, 0);
    chk(err_seen, 1);
    cmd(2'h1, 15'h0300, 7'h41, 0);
    chk({err_seen, wq.size()}, {1'b1, 32'h0000_0000});
    push(8'h11);
    cmd(2'h1, 15'h0300, 7'h02, 0);
    // second byte never comes inside the window
    chk({err_seen, wq.size()}, {1'b1, 32'h0000_0001});
    $display("t_bad finished");
  endtask
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 0;
    t_page();
    t_lock();
    t_bad();
    end_of_test();
  end
endmodule
